/* File: hw/ewc_pkg.sv */
// Package of constants for the exception and wait control block
package ewc_pkg;
    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [15:0] BRK_STATUS_IDX = 16'hFE00;
    localparam logic [15:0] BRK_FLAG_CTRL_IDX = 16'hFE03;
    localparam logic [15:0] PEND_LOW_IDX = 16'hFE04;
    localparam logic [15:0] PEND_HIGH_IDX = 16'hFE05;
    localparam int ADDR_W = 18;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int BREAK_EXIT_LOW_POWER_FLAG_BIT = 1;
    localparam int BREAK_FLAG_CLEAR_ENABLE_BIT = 7;
    localparam int PEND_LOW_LSB = 2;
    localparam logic BREAK_EXIT_LOW_POWER_FLAG_RST = 1'b0;
    localparam logic BREAK_FLAG_CLEAR_ENABLE_RST = 1'b0;
    localparam logic [7:0] PEND_RST = 8'h00;

    // ------------------------------------------------------------
    // Sources, vector codes and timing
    // ------------------------------------------------------------
    localparam int NUM_SRC = 9;
    localparam logic [3:0] VEC_TRAP = 4'h0;
    localparam int WAKE_DELAY = 1;

    typedef enum logic [1:0] {
        EWC_RUN,
        EWC_WAIT,
        EWC_WAKE
    } ewc_state_e;
endpackage

/* File: hw/ewc_exc_ctl.sv */
// Exception arbitration, break flag protection and wait control with APB registers
// Notes on behaviour
// - Interrupt entry asks the CPU to stack registers and set its mask flag.
// - Requests are latched and arbitrated, giving a vector selection code.
// - A latched request holds until serviced or the mask flag is set.
// - Interrupt entry only happens at an instruction boundary; the code also enters on trap, on wake and on break in wait without one.
// - Boundary entry needs mask flag clear and that source enabled.
// - Highest priority enabled request pending when the latch fills is taken first.
// - Handler return is a boundary, so a pending request is taken then.
// - Entry never asks the CPU to stack the index high register.
// - Software trap is taken whatever the mask flag says.
// - Trap stacks the program counter, hardware entry stacks it minus one.
// - Fixed priority reset, trap, then sources one to nine.
// - Low pending register is read-only, flags six to one in bits 7..2.
// - Pending flags follow request presence; high register holds nine to seven.
// - Reset overrides everything without arbitration.
// - Break request forces the trap vector and enters break state.
// - In break, flag clearing elsewhere is blocked unless clear enable set.
// - Flags cleared during break stay cleared after break ends.
// - Two-step clear sequences are restarted at break entry, staying protected.
// - Wait or stop instruction clears the CPU mask flag.
// - Wait stops CPU clock while peripheral clock keeps running.
// - Enabled request in wait wakes CPU, stacking one cycle later.
// - Reset or break leaves wait; break sets the exit flag.
// - Exit flag clears when software writes zero, and at reset.
// - Clear enable bit is read/write in the break flag control register.
module ewc_exc_ctl #(
    parameter int NSRC = ewc_pkg::NUM_SRC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ewc_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NSRC:1] irq_req,
    input wire logic [NSRC:1] irq_en,
    input wire logic cpu_mask_flag,
    input wire logic insn_done,
    input wire logic trap_exec,
    input wire logic rti_exec,
    input wire logic wait_exec,
    input wire logic stop_exec,
    input wire logic break_req,
    output logic int_take,
    output logic [3:0] vec_code,
    output logic push_pc_minus1,
    output logic push_index_high,
    output logic set_mask,
    output logic clr_mask,
    output logic cpu_clk_en,
    output logic periph_clk_en,
    output logic break_state,
    output logic flag_clr_allow,
    output logic flag_seq_restart
);
    // ------------------------------------------------------------
    // Priority encoder
    // ------------------------------------------------------------
    // Lowest index wins; shared by latch and wake paths
    function automatic logic [3:0] ewc_prio(input logic [NSRC:1] req);
        logic [3:0] code;
        code = 4'h0;
        for (int i = NSRC; i >= 1; i--) begin
            if (req[i]) begin
                code = 4'(i);
            end
        end
        return code;
    endfunction

    // ------------------------------------------------------------
    // Core state
    // ------------------------------------------------------------
    ewc_pkg::ewc_state_e state_r, state_nxt;
    logic [3:0] latch_code_r, latch_code_nxt;
    logic latch_vld_r, latch_vld_nxt;
    logic break_exit_low_power_flag_r, break_exit_low_power_flag_nxt;
    logic break_flag_clear_enable_r, break_flag_clear_enable_nxt;
    logic [NSRC:1] pend_r;
    logic brk_r, brk_nxt;

    // Request qualification
    wire logic [NSRC:1] req_ok = irq_req & irq_en;
    wire logic [3:0] req_code = ewc_prio(req_ok);
    wire logic any_req = |req_ok;
    wire logic boundary = insn_done | rti_exec;
    wire logic in_wait = (state_r == ewc_pkg::EWC_WAIT);
    // Handler return restores the mask, so a pending request goes before the next instruction
    wire logic eff_mask = cpu_mask_flag && !rti_exec;

    // Latch once unmasked; a newer, higher request cannot displace it
    wire logic do_latch = !latch_vld_r && any_req && !eff_mask;
    wire logic [3:0] cur_code = latch_vld_r ? latch_code_r : req_code;
    wire logic have_hw = latch_vld_r || do_latch;

    // Entry decisions, break above trap above hardware
    wire logic take_brk = break_req && !brk_r && (boundary || in_wait);
    wire logic take_trap = trap_exec && !take_brk;
    // The mask flag lags entry by one edge; block a second entry in that gap
    wire logic take_hw = boundary && have_hw && !eff_mask && !take_brk && !int_take
                         && !take_trap && state_r == ewc_pkg::EWC_RUN;
    wire logic wake_hw = (state_r == ewc_pkg::EWC_WAKE) && !take_brk;
    wire logic any_take = take_brk || take_trap || take_hw || wake_hw;

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    wire logic [15:0] idx = paddr[ewc_pkg::ADDR_W-1:2];
    wire logic sel_sbs = (idx == ewc_pkg::BRK_STATUS_IDX);
    wire logic sel_bfc = (idx == ewc_pkg::BRK_FLAG_CTRL_IDX);
    wire logic sel_pl = (idx == ewc_pkg::PEND_LOW_IDX);
    wire logic sel_ph = (idx == ewc_pkg::PEND_HIGH_IDX);
    wire logic mapped = sel_sbs | sel_bfc | sel_pl | sel_ph;
    wire logic setup = psel && !penable;
    wire logic wr_now = psel && penable && pready && pwrite;
    wire logic [7:0] pend_lo = {pend_r[6:1], 2'b00};
    wire logic [7:0] pend_hi = {5'b00000, pend_r[9:7]};
    wire logic [7:0] rd_mux = sel_sbs ? 8'(break_exit_low_power_flag_r) << ewc_pkg::BREAK_EXIT_LOW_POWER_FLAG_BIT :
                              sel_bfc ? 8'(break_flag_clear_enable_r) << ewc_pkg::BREAK_FLAG_CLEAR_ENABLE_BIT :
                              sel_pl ? pend_lo :
                              sel_ph ? pend_hi : 8'h00;

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    // Wait entry, wake and break bookkeeping
    always_comb begin
        state_nxt = state_r;
        latch_vld_nxt = latch_vld_r;
        latch_code_nxt = latch_code_r;
        break_exit_low_power_flag_nxt = break_exit_low_power_flag_r;
        break_flag_clear_enable_nxt = break_flag_clear_enable_r;
        brk_nxt = brk_r;
        case (state_r)
            ewc_pkg::EWC_RUN: begin
                if (wait_exec && !any_take) begin
                    state_nxt = ewc_pkg::EWC_WAIT;
                end
            end
            ewc_pkg::EWC_WAIT: begin
                if (take_brk) begin
                    state_nxt = ewc_pkg::EWC_RUN;
                end else if (any_req) begin
                    state_nxt = ewc_pkg::EWC_WAKE;
                    latch_vld_nxt = 1'b1;
                    latch_code_nxt = cur_code;
                end
            end
            ewc_pkg::EWC_WAKE: begin
                state_nxt = ewc_pkg::EWC_RUN;
            end
            default: begin
                state_nxt = ewc_pkg::EWC_RUN;
            end
        endcase
        // Latch release: serviced, or the CPU masked again
        if (do_latch && state_r == ewc_pkg::EWC_RUN) begin
            latch_vld_nxt = 1'b1;
            latch_code_nxt = req_code;
        end
        if (take_hw || wake_hw || (latch_vld_r && cpu_mask_flag)) begin
            latch_vld_nxt = 1'b0;
        end
        // Software writes zero to clear; a break wake in that cycle wins
        if (wr_now && sel_sbs && !pwdata[ewc_pkg::BREAK_EXIT_LOW_POWER_FLAG_BIT]) begin
            break_exit_low_power_flag_nxt = 1'b0;
        end
        if (take_brk && in_wait) begin
            break_exit_low_power_flag_nxt = 1'b1;
        end
        if (wr_now && sel_bfc) begin
            break_flag_clear_enable_nxt = pwdata[ewc_pkg::BREAK_FLAG_CLEAR_ENABLE_BIT];
        end
        if (take_brk) begin
            brk_nxt = 1'b1;
        end else if (rti_exec && brk_r) begin
            brk_nxt = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // Reset is asynchronous and beats every request
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ewc_pkg::EWC_RUN;
            latch_vld_r <= 1'b0;
            latch_code_r <= ewc_pkg::VEC_TRAP;
            break_exit_low_power_flag_r <= ewc_pkg::BREAK_EXIT_LOW_POWER_FLAG_RST;
            break_flag_clear_enable_r <= ewc_pkg::BREAK_FLAG_CLEAR_ENABLE_RST;
            brk_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            latch_vld_r <= latch_vld_nxt;
            latch_code_r <= latch_code_nxt;
            break_exit_low_power_flag_r <= break_exit_low_power_flag_nxt;
            break_flag_clear_enable_r <= break_flag_clear_enable_nxt;
            brk_r <= brk_nxt;
        end
    end

    // Pending flags mirror raw requests, enabled or not
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_r <= NSRC'(ewc_pkg::PEND_RST);
        end else begin
            pend_r <= irq_req;
        end
    end

    // CPU-facing strobes, one cycle each
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_take <= 1'b0;
            vec_code <= ewc_pkg::VEC_TRAP;
            push_pc_minus1 <= 1'b0;
            push_index_high <= 1'b0;
            set_mask <= 1'b0;
            clr_mask <= 1'b0;
        end else begin
            int_take <= any_take;
            vec_code <= (take_brk || take_trap) ? ewc_pkg::VEC_TRAP : cur_code;
            push_pc_minus1 <= take_hw || wake_hw;
            push_index_high <= 1'b0;
            set_mask <= any_take;
            clr_mask <= wait_exec || stop_exec;
        end
    end

    // Clock gating and break protection outputs
    // Restart pulse makes any half-done two-step clear start over
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_clk_en <= 1'b1;
            periph_clk_en <= 1'b1;
            break_state <= 1'b0;
            flag_clr_allow <= 1'b1;
            flag_seq_restart <= 1'b0;
        end else begin
            cpu_clk_en <= (state_nxt == ewc_pkg::EWC_RUN);
            periph_clk_en <= 1'b1;
            break_state <= brk_nxt;
            flag_clr_allow <= !brk_nxt || break_flag_clear_enable_nxt;
            flag_seq_restart <= take_brk;
        end
    end

    // APB slave, no wait states, error on unmapped index
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= setup;
            pslverr <= setup && !mapped;
            prdata <= setup && !pwrite ? {24'h000000, rd_mux} : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_trap_unmasked: assert property (@(posedge pclk) disable iff (!presetn)
        trap_exec && cpu_mask_flag && !take_brk |=> int_take && vec_code == ewc_pkg::VEC_TRAP)
        else $error("trap not taken while masked");
    a_masked_no_take: assert property (@(posedge pclk) disable iff (!presetn)
        cpu_mask_flag && !rti_exec && !trap_exec && !break_req && state_r == ewc_pkg::EWC_RUN |=> !int_take)
        else $error("hardware entry while masked");
    a_boundary_only: assert property (@(posedge pclk) disable iff (!presetn)
        state_r == ewc_pkg::EWC_RUN && !boundary && !trap_exec |=> !int_take)
        else $error("entry outside instruction boundary");
    a_prio_lowest: assert property (@(posedge pclk) disable iff (!presetn)
        take_hw && !latch_vld_r |=> vec_code == ewc_prio($past(req_ok)))
        else $error("wrong priority chosen");
    a_latch_held: assert property (@(posedge pclk) disable iff (!presetn)
        latch_vld_r && !cpu_mask_flag && !take_hw && !wake_hw |=> latch_code_r == $past(latch_code_r))
        else $error("latched request displaced");
    a_index_high: assert property (@(posedge pclk) disable iff (!presetn)
        int_take |-> !push_index_high)
        else $error("index high push requested");
    a_pc_minus: assert property (@(posedge pclk) disable iff (!presetn)
        int_take && vec_code == ewc_pkg::VEC_TRAP |-> !push_pc_minus1)
        else $error("trap stacked pc minus one");
    a_mask_clear: assert property (@(posedge pclk) disable iff (!presetn)
        wait_exec || stop_exec |=> clr_mask)
        else $error("mask not cleared on wait or stop");
    a_wake_delay: assert property (@(posedge pclk) disable iff (!presetn)
        in_wait && any_req && !break_req |=> !cpu_clk_en ##1 int_take && cpu_clk_en)
        else $error("wake stacking not one cycle later");
    a_break_flag: assert property (@(posedge pclk) disable iff (!presetn)
        in_wait && break_req && !brk_r |=> break_exit_low_power_flag_r && int_take)
        else $error("break wake did not set exit flag");
    a_protect: assert property (@(posedge pclk) disable iff (!presetn)
        break_state && !break_flag_clear_enable_r |-> !flag_clr_allow)
        else $error("flags clearable in break without enable");
    a_pend_low: assert property (@(posedge pclk) disable iff (!presetn)
        setup && !pwrite && sel_pl |=> prdata[1:0] == 2'b00 && prdata[7:2] == $past(pend_r[6:1]))
        else $error("pending low read wrong");
    // Entry, wake, clock and register side effects; clock and clear-allow checks in the same cycle, the rest one edge after the cause
    a_rti_entry: assert property (@(posedge pclk) disable iff (!presetn)
        rti_exec && (latch_vld_r || any_req) && !break_req && !trap_exec && !int_take
        && state_r == ewc_pkg::EWC_RUN |=> int_take && push_pc_minus1)
        else $error("pending request not taken at handler return");
    a_latch_mask: assert property (@(posedge pclk) disable iff (!presetn)
        latch_vld_r && cpu_mask_flag |=> !latch_vld_r)
        else $error("latch kept after mask set");
    a_periph_clk: assert property (@(posedge pclk) disable iff (!presetn)
        periph_clk_en)
        else $error("peripheral clock stopped");
    a_wait_gate: assert property (@(posedge pclk) disable iff (!presetn)
        in_wait |-> !cpu_clk_en)
        else $error("cpu clock running in wait");
    a_wake_vec: assert property (@(posedge pclk) disable iff (!presetn)
        wake_hw |=> int_take && push_pc_minus1 && vec_code == $past(latch_code_r))
        else $error("wake entry wrong");
    a_brk_vec: assert property (@(posedge pclk) disable iff (!presetn)
        take_brk |=> int_take && vec_code == ewc_pkg::VEC_TRAP && !push_pc_minus1)
        else $error("break did not force trap vector");
    a_seq_restart: assert property (@(posedge pclk) disable iff (!presetn)
        take_brk |=> flag_seq_restart && break_state)
        else $error("two-step clear not restarted");
    a_allow_clr: assert property (@(posedge pclk) disable iff (!presetn)
        !break_state || break_flag_clear_enable_r |-> flag_clr_allow)
        else $error("flag clearing blocked wrongly");
    a_exit_clear: assert property (@(posedge pclk) disable iff (!presetn)
        wr_now && sel_sbs && !pwdata[ewc_pkg::BREAK_EXIT_LOW_POWER_FLAG_BIT] && !(take_brk && in_wait) |=> !break_exit_low_power_flag_r)
        else $error("exit flag not cleared by write");
    a_break_flag_clear_enable_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr_now && sel_bfc |=> break_flag_clear_enable_r == $past(pwdata[ewc_pkg::BREAK_FLAG_CLEAR_ENABLE_BIT]))
        else $error("clear enable write lost");
    a_pend_high: assert property (@(posedge pclk) disable iff (!presetn)
        setup && !pwrite && sel_ph |=> prdata[7:3] == 5'h00 && prdata[2:0] == $past(pend_r[9:7]))
        else $error("pending high read wrong");
    a_trap_pc: assert property (@(posedge pclk) disable iff (!presetn)
        take_trap |=> int_take && !push_pc_minus1)
        else $error("trap stacked wrong pc");
endmodule

/* File: bench/ewc_cpu_model.sv */
// Behavioural CPU core that faces the exception block: instruction boundaries and mask flag
module ewc_cpu_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic set_mask,
    input wire logic clr_mask,
    input wire logic cpu_clk_en,
    input wire logic rti_exec,
    input wire logic cli_req,
    output logic cpu_mask_flag,
    output logic insn_done
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] phase_r;
    // -----------------------------------------------------------------
    // Mask flag
    // -----------------------------------------------------------------
    // Mask leaves reset set, as a core does on its reset vector
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_mask_flag <= 1'b1;
        end else if (set_mask) begin
            cpu_mask_flag <= 1'b1;
        end else if (clr_mask || rti_exec || cli_req) begin
            cpu_mask_flag <= 1'b0;
        end
    end
    // -----------------------------------------------------------------
    // Instruction boundaries
    // -----------------------------------------------------------------
    // One instruction per four clocks; none while the core clock is gated off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_r <= 2'h0;
            insn_done <= 1'b0;
        end else begin
            phase_r <= cpu_clk_en ? phase_r + 2'h1 : phase_r;
            insn_done <= cpu_clk_en && (phase_r == 2'h3);
        end
    end
endmodule

/* File: bench/testbench.sv */
// Self-checking bench for the exception and wait control block
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, psel, penable, pwrite, break_req, pready, pslverr, rerr, mask, insn_done;
    logic int_take, pcm1, idxh, set_mask, clr_mask, cpu_clk_en, periph_clk_en, break_state;
    logic flag_clr_allow, flag_seq_restart;
    logic [ewc_pkg::ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [ewc_pkg::NUM_SRC:1] irq_req, irq_en;
    logic [3:0] vec_code;
    logic [4:0] cmd;
    int errors = 0;
    int cmp_count = 0;
    int cycles = 0;
    int take_cnt = 0;
    ewc_exc_ctl i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .irq_req(irq_req), .irq_en(irq_en), .cpu_mask_flag(mask), .insn_done(insn_done),
        .trap_exec(cmd[0]), .rti_exec(cmd[1]), .wait_exec(cmd[2]), .stop_exec(cmd[3]),
        .break_req(break_req), .int_take(int_take), .vec_code(vec_code), .push_pc_minus1(pcm1),
        .push_index_high(idxh), .set_mask(set_mask), .clr_mask(clr_mask), .cpu_clk_en(cpu_clk_en),
        .periph_clk_en(periph_clk_en), .break_state(break_state), .flag_clr_allow(flag_clr_allow),
        .flag_seq_restart(flag_seq_restart));
    ewc_cpu_model i_cpu (.pclk(pclk), .presetn(presetn), .set_mask(set_mask), .clr_mask(clr_mask),
        .cpu_clk_en(cpu_clk_en), .rti_exec(cmd[1]), .cli_req(cmd[4]), .cpu_mask_flag(mask),
        .insn_done(insn_done));
    // -----------------------------------------------------------------
    // Helpers
    // -----------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // APB transfer; the request stands until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) errors++;
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] idx, input logic [31:0] exp, input logic err);
        apb(1'b0, idx, 32'h0);
        chk("prdata", rdat, exp);
        chk("pslverr", {31'h0, rerr}, {31'h0, err});
    endtask
    // One-cycle CPU event pulse; returns at the edge that samples it
    task automatic fire(input logic [4:0] c);
        @(posedge pclk);
        cmd <= c;
        @(posedge pclk);
        cmd <= 5'h00;
    endtask
    // Bounded wait for interrupt entry, then its qualifiers
    task automatic take(input logic [3:0] v, input logic m1);
        int n;
        n = 0;
        do begin
            @(negedge pclk);
            n++;
        end while (int_take !== 1'b1 && n < 40);
        chk("int_take", {31'h0, int_take}, 32'h1);
        chk("vec_code", {28'h0, vec_code}, {28'h0, v});
        chk("push_pc_minus1", {31'h0, pcm1}, {31'h0, m1});
        chk("set_mask", {31'h0, set_mask}, 32'h1);
        chk("push_index_high", {31'h0, idxh}, 32'h0);
        @(posedge pclk);
    endtask
    // -----------------------------------------------------------------
    // Clock, entry counter and hang guard
    // -----------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cycles++;
        if (int_take === 1'b1) take_cnt++;
        if (cycles == 20000) begin
            errors++;
            tally_and_finish();
        end
    end
    // -----------------------------------------------------------------
    // Main sequence
    // -----------------------------------------------------------------
    initial begin
        {psel, penable, pwrite, break_req, presetn} = 5'h00;
        paddr = '0;
        pwdata = 32'h0;
        cmd = 5'h00;
        irq_req = '0;
        irq_en = '0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        chk("cpu_clk_en", {31'h0, cpu_clk_en}, 32'h1);
        chk("periph_clk_en", {31'h0, periph_clk_en}, 32'h1);
        chk("flag_clr_allow", {31'h0, flag_clr_allow}, 32'h1);
        rd(ewc_pkg::BRK_STATUS_IDX, 32'h0, 1'b0);
        rd(ewc_pkg::BRK_FLAG_CTRL_IDX, 32'h0, 1'b0);
        rd(ewc_pkg::PEND_LOW_IDX, 32'h0, 1'b0);
        $display("test reset done");
        // Walk each source across the two pending registers, mask still set
        irq_en <= '1;
        for (int s = 1; s <= 9; s++) begin
            irq_req <= 9'h001 << (s - 1);
            repeat (3) @(posedge pclk);
            rd(ewc_pkg::PEND_LOW_IDX, (s <= 6) ? (32'h1 << (s + 1)) : 32'h0, 1'b0);
            rd(ewc_pkg::PEND_HIGH_IDX, (s > 6) ? (32'h1 << (s - 7)) : 32'h0, 1'b0);
        end
        irq_req <= 9'h1FF;
        apb(1'b1, ewc_pkg::PEND_LOW_IDX, 32'h0);
        rd(ewc_pkg::PEND_LOW_IDX, 32'hFC, 1'b0);
        rd(16'h0010, 32'h0, 1'b1);
        chk("take_cnt", take_cnt, 0);
        $display("test pending done");
        // Unmasked but disabled requests must not enter
        irq_en <= '0;
        irq_req <= 9'h014;
        fire(5'h10);
        repeat (20) @(posedge pclk);
        chk("take_cnt", take_cnt, 0);
        irq_en <= '1;
        take(4'h3, 1'b1);
        irq_req <= 9'h010;
        fire(5'h02);
        take(4'h5, 1'b1);
        irq_req <= 9'h000;
        fire(5'h01);
        take(ewc_pkg::VEC_TRAP, 1'b0);
        $display("test entry done");
        // Wait, then wake by an enabled request
        fire(5'h04);
        @(negedge pclk);
        chk("clr_mask", {31'h0, clr_mask}, 32'h1);
        chk("cpu_clk_en", {31'h0, cpu_clk_en}, 32'h0);
        chk("periph_clk_en", {31'h0, periph_clk_en}, 32'h1);
        @(posedge pclk);
        irq_req <= 9'h001;
        repeat (2) @(negedge pclk);
        chk("cpu_clk_en", {31'h0, cpu_clk_en}, 32'h0);
        chk("int_take", {31'h0, int_take}, 32'h0);
        take(4'h1, 1'b1);
        chk("cpu_clk_en", {31'h0, cpu_clk_en}, 32'h1);
        irq_req <= 9'h000;
        fire(5'h02);
        $display("test wait done");
        // Break during wait
        fire(5'h04);
        @(posedge pclk);
        break_req <= 1'b1;
        repeat (2) @(negedge pclk);
        chk("int_take", {31'h0, int_take}, 32'h1);
        chk("vec_code", {28'h0, vec_code}, {28'h0, ewc_pkg::VEC_TRAP});
        chk("break_state", {31'h0, break_state}, 32'h1);
        chk("flag_clr_allow", {31'h0, flag_clr_allow}, 32'h0);
        chk("flag_seq_restart", {31'h0, flag_seq_restart}, 32'h1);
        @(posedge pclk);
        break_req <= 1'b0;
        rd(ewc_pkg::BRK_STATUS_IDX, 32'h2, 1'b0);
        apb(1'b1, ewc_pkg::BRK_FLAG_CTRL_IDX, 32'h80);
        rd(ewc_pkg::BRK_FLAG_CTRL_IDX, 32'h80, 1'b0);
        chk("flag_clr_allow", {31'h0, flag_clr_allow}, 32'h1);
        apb(1'b1, ewc_pkg::BRK_STATUS_IDX, 32'h0);
        rd(ewc_pkg::BRK_STATUS_IDX, 32'h0, 1'b0);
        fire(5'h02);
        @(negedge pclk);
        chk("break_state", {31'h0, break_state}, 32'h0);
        fire(5'h08);
        @(negedge pclk);
        chk("clr_mask", {31'h0, clr_mask}, 32'h1);
        $display("test break done");
        tally_and_finish();
    end
endmodule
